/* shared/osc_pll_pkg.sv */
// Constants shared by the oscillator and PLL clock generator control logic.
// Assumes every consumer imports the whole package.
package osc_pll_pkg;
  // Field widths of the configuration and status ports and of the PLL credit counter.
  localparam int STARTUP_W = 8;
  localparam int RATIO_W = 8;
  localparam int FACTOR_W = 11;
  localparam int SETTLE_W = 6;
  localparam int FREQ_W = 16;
  localparam int CREDIT_W = 16;
  // Longest main oscillator start-up wait in milliseconds.
  localparam int STARTUP_MAX_MS = 62;
  // Slow clock prescale: the start-up counter steps once every eight slow rising edges.
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  // Frequency measurement runs from a slow rise to the sixteenth slow fall: fifteen and a half periods.
  localparam logic [4:0] MEASURE_LAST = 5'h0F;
  // Values after reset.
  localparam logic [STARTUP_W-1:0] STARTUP_RESET = 8'h00;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h00;
  localparam logic [FACTOR_W-1:0] FACTOR_RESET = 11'h000;
  localparam logic [SETTLE_W-1:0] SETTLE_RESET = 6'h00;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
  // Frequency measurement sequencer states.
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARM, MEAS_RUN, MEAS_DONE} meas_e;
endpackage

/* hdl/osc_pll_clock_generator.sv */
// Control logic of the slow clock, main oscillator and divider plus PLL clock generator.
// Assumes slow_clock and crystal_in_pin are plain levels sampled on ref_clk at 50 MHz.
`timescale 1ns/1ps
module osc_pll_clock_generator (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Oscillator pins.
  input wire logic slow_clock,
  input wire logic crystal_in_pin,
  // Main oscillator configuration, taken on mainOscWrite.
  input wire logic mainOscWrite,
  input wire logic main_osc_enable,
  input wire logic [osc_pll_pkg::STARTUP_W-1:0] osc_startup_count,
  input wire logic osc_bypass_a,
  // PLL configuration, taken on pllWrite.
  input wire logic pllWrite,
  input wire logic [osc_pll_pkg::RATIO_W-1:0] pll_input_ratio,
  input wire logic [osc_pll_pkg::FACTOR_W-1:0] pll_factor,
  input wire logic [osc_pll_pkg::SETTLE_W-1:0] pll_settle_count,
  // Source selection request.
  input wire logic selectMain,
  // Clock outputs.
  output logic main_osc_clock,
  output logic dividerOut,
  output logic pll_out_clock,
  output logic clockSelMain,
  // Status.
  output logic main_osc_stable,
  output logic freq_measure_ready,
  output logic [osc_pll_pkg::FREQ_W-1:0] main_freq_count,
  output logic pll_settled
);
  import osc_pll_pkg::*;

  // Step a counter down, holding at zero.
  function automatic logic [STARTUP_W-1:0] dec_nz(input logic [STARTUP_W-1:0] v);
    dec_nz = (v != '0) ? v - 8'h01 : v;
  endfunction

  logic slowS1_reg, slowS2_reg, slowS3_reg;
  logic xtalS1_reg, xtalS2_reg, xtalS3_reg;
  logic oscEnable_reg, bypass_reg, stable_reg, stableDly_reg;
  logic [STARTUP_W-1:0] startupCnt_reg, startupCnt_next;
  logic [2:0] prescale_reg;
  logic stable_next;
  meas_e measState_reg, measState_next;
  logic [4:0] periods_reg;
  logic [FREQ_W-1:0] freqCnt_reg;
  logic ready_reg;
  logic [RATIO_W-1:0] ratio_reg;
  logic [FACTOR_W-1:0] factor_reg;
  logic [SETTLE_W-1:0] settleCnt_reg, settleCnt_next;
  logic [SETTLE_W-1:0] settleCfg_reg;
  logic settled_reg, settled_next;
  logic [RATIO_W-1:0] divCnt_reg;
  logic divOut_reg, pllOut_reg, mainClk_reg, selMain_reg;
  logic [CREDIT_W-1:0] credit_reg, credit_next;

  // Two-flop synchronisers, third stage only for edge detection.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {slowS1_reg, slowS2_reg, slowS3_reg} <= 3'h0;
      {xtalS1_reg, xtalS2_reg, xtalS3_reg} <= 3'h0;
    end else begin
      {slowS1_reg, slowS2_reg, slowS3_reg} <= {slow_clock, slowS1_reg, slowS2_reg};
      {xtalS1_reg, xtalS2_reg, xtalS3_reg} <= {crystal_in_pin, xtalS1_reg, xtalS2_reg};
    end
  end

  // Edge strobes; start-up, settle and measurement timing step on slow clock edges, the divider on crystal edges.
  wire slowRise = slowS2_reg & ~slowS3_reg;
  wire slowFall = ~slowS2_reg & slowS3_reg;
  wire mainLive = bypass_reg | stable_reg;
  wire srcEdge = xtalS2_reg & ~xtalS3_reg & mainLive;
  wire startReq = mainOscWrite & main_osc_enable;
  wire stopReq = mainOscWrite & ~main_osc_enable;
  wire prescaleTick = slowRise & (prescale_reg == PRESCALE_LAST);
  wire stableRise = stable_reg & ~stableDly_reg;

  // Start-up counter and stable flag.
  always_comb begin
    startupCnt_next = startupCnt_reg;
    if (startReq) begin
      startupCnt_next = osc_startup_count;
    end else if (prescaleTick) begin
      startupCnt_next = dec_nz(startupCnt_reg);
    end
  end
  assign stable_next = (stopReq | startReq | ~oscEnable_reg) ? 1'b0 :
                       (startupCnt_reg == '0) ? 1'b1 : stable_reg;

  // Oscillator configuration and start-up state.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oscEnable_reg <= 1'b0;
      bypass_reg <= 1'b0;
      startupCnt_reg <= STARTUP_RESET;
      prescale_reg <= 3'h0;
      stable_reg <= 1'b0;
      stableDly_reg <= 1'b0;
    end else begin
      if (mainOscWrite) begin
        oscEnable_reg <= main_osc_enable;
        bypass_reg <= osc_bypass_a;
      end
      startupCnt_reg <= startupCnt_next;
      prescale_reg <= startReq ? 3'h0 : prescale_reg + {2'h0, slowRise};
      stable_reg <= stable_next;
      stableDly_reg <= stable_reg;
    end
  end

  // Frequency measurement sequencer.
  always_comb begin
    measState_next = measState_reg;
    unique case (measState_reg)
      MEAS_IDLE: measState_next = MEAS_IDLE;
      MEAS_ARM: if (slowRise) measState_next = MEAS_RUN;
      MEAS_RUN: if (slowFall && periods_reg == MEASURE_LAST) measState_next = MEAS_DONE;
      MEAS_DONE: measState_next = MEAS_DONE;
    endcase
    if (stableRise) measState_next = MEAS_ARM;
    if (!oscEnable_reg) measState_next = MEAS_IDLE;
  end

  // Measurement counters; the count saturates rather than wrapping.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      measState_reg <= MEAS_IDLE;
      periods_reg <= 5'h00;
      freqCnt_reg <= FREQ_RESET;
      ready_reg <= 1'b0;
    end else begin
      measState_reg <= measState_next;
      ready_reg <= (measState_next == MEAS_DONE);
      if (measState_next == MEAS_IDLE || measState_next == MEAS_ARM) begin
        periods_reg <= 5'h00;
        freqCnt_reg <= FREQ_RESET;
      end else if (measState_reg == MEAS_RUN) begin
        periods_reg <= periods_reg + {4'h0, slowFall};
        if (srcEdge && freqCnt_reg != '1) freqCnt_reg <= freqCnt_reg + 16'h0001;
      end
    end
  end

  // Twice the factor plus two: the output toggles once per credit, two toggles a cycle.
  function automatic logic [FACTOR_W+1:0] pll_factor_inc(input logic [FACTOR_W-1:0] f);
    pll_factor_inc = {1'b0, f, 1'b0} + 13'h0002;
  endfunction

  // PLL enable and change detection; a repeat of the stored setting restarts settling only while not settled.
  wire pllOn = (factor_reg != '0) & (ratio_reg != '0);
  wire pllChange = pllWrite & ((pll_input_ratio != ratio_reg) | (pll_factor != factor_reg) |
                               (pll_settle_count != settleCfg_reg) | ~settled_reg);
  wire divTick = srcEdge & (divCnt_reg == '0) & (ratio_reg != '0);
  wire [CREDIT_W-1:0] creditAdd = {3'h0, pll_factor_inc(factor_reg)};
  wire [CREDIT_W:0] creditSum = {1'b0, credit_reg - {15'h0000, credit_reg != '0}} +
                                {1'b0, divTick ? creditAdd : 16'h0000};

  // Settle counter and settled flag.
  always_comb begin
    settleCnt_next = settleCnt_reg;
    if (pllChange) begin
      settleCnt_next = pll_settle_count;
    end else if (slowRise) begin
      settleCnt_next = SETTLE_W'(dec_nz({2'h0, settleCnt_reg}));
    end
  end
  assign settled_next = (pllChange || !pllOn) ? 1'b0 :
                        (settleCnt_reg == '0) ? 1'b1 : settled_reg;
  assign credit_next = !pllOn ? '0 : creditSum[CREDIT_W] ? '1 : creditSum[CREDIT_W-1:0];

  // PLL configuration and settle state.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_reg <= RATIO_RESET;
      factor_reg <= FACTOR_RESET;
      settleCnt_reg <= SETTLE_RESET;
      settleCfg_reg <= SETTLE_RESET;
      settled_reg <= 1'b0;
    end else begin
      if (pllWrite) begin
        ratio_reg <= pll_input_ratio;
        factor_reg <= pll_factor;
        settleCfg_reg <= pll_settle_count;
      end
      settleCnt_reg <= settleCnt_next;
      settled_reg <= settled_next;
    end
  end

  // Divider counts source edges modulo the ratio; PLL spends credits as toggles.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 8'h00;
      credit_reg <= '0;
      divOut_reg <= 1'b0;
      pllOut_reg <= 1'b0;
    end else begin
      if (ratio_reg == '0 || pllWrite) divCnt_reg <= 8'h00;
      else if (srcEdge) divCnt_reg <= (divCnt_reg >= ratio_reg - 8'h01) ? 8'h00 :
                                      divCnt_reg + 8'h01;
      divOut_reg <= (ratio_reg != '0) & mainLive & ((ratio_reg == 8'h01) ? xtalS2_reg :
                    (divCnt_reg < (ratio_reg >> 1)));
      credit_reg <= credit_next;
      pllOut_reg <= pllOn & (pllOut_reg ^ (credit_reg != '0));
    end
  end

  // Main clock output and source selection.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mainClk_reg <= 1'b0;
      selMain_reg <= 1'b0;
    end else begin
      mainClk_reg <= mainLive & xtalS2_reg;
      selMain_reg <= selectMain & mainLive;
    end
  end

  assign main_osc_clock = mainClk_reg;
  assign pll_out_clock = pllOut_reg;
  assign dividerOut = divOut_reg;
  assign clockSelMain = selMain_reg;
  assign main_osc_stable = stable_reg;
  assign freq_measure_ready = ready_reg;
  assign main_freq_count = freqCnt_reg;
  assign pll_settled = settled_reg;

  // Checks run on the reference clock and rest while reset is held.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence startSeq;
    startReq ##1 !main_osc_stable;
  endsequence

  osc_off_clears_a: assert property (stopReq |=> !main_osc_stable)
    else $error("stable flag survived an oscillator disable");
  start_clears_a: assert property (startReq |-> startSeq)
    else $error("stable flag not cleared on start-up write");
  startup_load_a: assert property (startReq
    |=> startupCnt_reg == $past(osc_startup_count))
    else $error("start-up counter not loaded");
  prescale_step_a: assert property (prescaleTick && startupCnt_reg != '0
    && !mainOscWrite |=> startupCnt_reg == $past(startupCnt_reg) - 8'h01)
    else $error("start-up counter missed a prescaled step");
  stable_set_a: assert property (oscEnable_reg && startupCnt_reg == '0
    && !mainOscWrite |=> main_osc_stable)
    else $error("stable flag not set at zero count");
  measure_done_a: assert property (measState_reg == MEAS_RUN && slowFall
    && periods_reg == MEASURE_LAST && oscEnable_reg && !stableRise |=> freq_measure_ready)
    else $error("ready not set at the sixteenth falling edge");
  measure_off_a: assert property (!oscEnable_reg
    |=> !freq_measure_ready && main_freq_count == '0)
    else $error("measurement not cleared while oscillator off");
  // Each rise of the stable flag throws away any earlier result.
  measure_arm_a: assert property (stableRise && oscEnable_reg
    |=> !freq_measure_ready && main_freq_count == '0)
    else $error("measurement not restarted on a stable rise");
  ratio_zero_a: assert property (ratio_reg == '0 |=> !pll_out_clock && !dividerOut)
    else $error("outputs not low with ratio zero");
  pll_change_a: assert property (pllChange
    |=> !pll_settled && settleCnt_reg == $past(pll_settle_count))
    else $error("PLL change did not restart settling");
  settle_step_a: assert property (slowRise && settleCnt_reg != '0 && !pllWrite
    |=> settleCnt_reg == $past(settleCnt_reg) - 6'h01)
    else $error("settle counter missed a slow step");
  // Settling ends one cycle after the counter empties, provided the PLL is running.
  settle_done_a: assert property (pllOn && settleCnt_reg == '0 && !pllWrite
    |=> pll_settled)
    else $error("settled flag not set at zero count");
  // A stopped PLL can never report itself settled.
  pll_off_a: assert property (!pllOn |=> !pll_settled)
    else $error("settled flag high with the PLL off");
  select_slow_a: assert property (!mainLive |=> !clockSelMain)
    else $error("main selected while unavailable");
endmodule

/* tb/clock_source_model.sv */
// Far side of the clock generator: slow RC clock and crystal or external clock.
// Assumes the bench holds run high while the oscillator is enabled or bypassed.
`timescale 1ns/1ps
module clock_source_model #(
  parameter int SLOW_HALF = 400,
  parameter int XTAL_HALF = 50
) (
  // Control.
  input wire logic run,
  // Clock levels.
  output logic slowClk,
  output logic xtalClk
);
  // The slow clock never stops, even while the oscillator is off.
  initial begin
    slowClk = 1'b0;
    forever #(SLOW_HALF) slowClk = ~slowClk;
  end
  // The crystal swings only while powered and rests low otherwise.
  initial begin
    xtalClk = 1'b0;
    // Keep the crystal edges off the reference clock edges at which the pin is sampled.
    #5;
    forever begin
      #(XTAL_HALF);
      xtalClk = run ? ~xtalClk : 1'b0;
    end
  end
endmodule

/* tb/osc_pll_clock_generator_bench.sv */
// Self-checking bench for the oscillator and PLL clock generator control logic.
// Assumes clock_source_model stands for the slow clock and crystal pins.
`timescale 1ns/1ps
module osc_pll_clock_generator_bench;
  import osc_pll_pkg::*;
  localparam int SLOW_P = 800;
  localparam int XTAL_P = 100;
  localparam int WIN = 400;
  logic refClk = 1'b0;
  logic rstn, mainOscWrite, mainOscEn, bypass, pllWrite, selectMain;
  logic [STARTUP_W-1:0] startCnt;
  logic [RATIO_W-1:0] ratio;
  logic [FACTOR_W-1:0] factor;
  logic [SETTLE_W-1:0] settle;
  logic mainClk, divOut, pllClk, selMain, stable, ready, settled, slowClk, xtalClk;
  logic [FREQ_W-1:0] freqCount;
  int miscompares = 0;
  int nTests = 0;
  int slowRises = 0;
  int ratioQ[$] = '{1, 3, 0, 2, 1};
  int factorQ[$] = '{1, 1, 3, 0, 2047};
  int n, r0, i, r, f, s, pllT, divR, mainT, e;
  bit on;

  clock_source_model #(.SLOW_HALF(SLOW_P / 2), .XTAL_HALF(XTAL_P / 2)) src_u (
    .run(mainOscEn | bypass), .slowClk(slowClk), .xtalClk(xtalClk));

  osc_pll_clock_generator dut_u (
    .ref_clk(refClk), .rstn(rstn), .slow_clock(slowClk), .crystal_in_pin(xtalClk),
    .mainOscWrite(mainOscWrite), .main_osc_enable(mainOscEn), .osc_startup_count(startCnt),
    .osc_bypass_a(bypass), .pllWrite(pllWrite), .pll_input_ratio(ratio),
    .pll_factor(factor), .pll_settle_count(settle), .selectMain(selectMain),
    .main_osc_clock(mainClk), .dividerOut(divOut), .pll_out_clock(pllClk),
    .clockSelMain(selMain), .main_osc_stable(stable), .freq_measure_ready(ready),
    .main_freq_count(freqCount), .pll_settled(settled));

  // Reference clock at 50 MHz and a count of slow clock rises.
  always #10 refClk = ~refClk;
  always @(posedge slowClk) slowRises++;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_in(input logic [31:0] got, input int lo, input int hi);
    int g;
    g = got;
    nTests++;
    if ($isunknown(got) || g < lo || g > hi) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
    end
  endtask

  // Pulses a configuration write and returns once its answer has landed.
  task automatic osc_write(input logic en, input logic [7:0] cnt, input logic byp);
    @(negedge refClk);
    mainOscEn = en;
    startCnt = cnt;
    bypass = byp;
    mainOscWrite = 1'b1;
    @(negedge refClk);
    mainOscWrite = 1'b0;
    @(negedge refClk);
  endtask

  task automatic pll_write(input int rt, input int fc, input int st);
    @(negedge refClk);
    ratio = rt[7:0];
    factor = fc[10:0];
    settle = st[5:0];
    pllWrite = 1'b1;
    @(negedge refClk);
    pllWrite = 1'b0;
    @(negedge refClk);
  endtask

  // Waits for a status flag (0 stable, 1 ready, 2 settled); a timeout counts as a mismatch.
  task automatic wait_high(input int which, input int lim);
    int k;
    logic v;
    k = 0;
    v = 1'b0;
    while (v !== 1'b1 && k < lim) begin
      @(negedge refClk);
      v = (which == 0) ? stable : (which == 1) ? ready : settled;
      k++;
    end
    if (v !== 1'b1) begin
      miscompares++;
      $display("ERROR at %0t: flag %0h stayed low, expected %0h", $time, which, 1);
    end
  endtask

  // Counts output activity over a fixed window of reference cycles.
  task automatic watch();
    logic p, d, m;
    pllT = 0;
    divR = 0;
    mainT = 0;
    p = pllClk;
    d = divOut;
    m = mainClk;
    repeat (WIN) begin
      @(negedge refClk);
      if (pllClk !== p) pllT++;
      if (divOut === 1'b1 && d === 1'b0) divR++;
      if (mainClk !== m) mainT++;
      p = pllClk;
      d = divOut;
      m = mainClk;
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 100 us.
  initial begin
    #(600000);
    miscompares++;
    final_report();
  end

  // Main sequence.
  initial begin
    {rstn, mainOscWrite, mainOscEn, bypass, pllWrite} = 5'h00;
    {startCnt, ratio, factor, settle} = '0;
    selectMain = 1'b1;
    void'($urandom(32'h298bcf7f));
    repeat (12) @(negedge refClk);
    rstn = 1'b1;
    @(negedge refClk);
    check({stable, selMain, mainClk}, 3'h0);
    check({divOut, pllClk, settled}, 3'h0);
    $display("reset test done");
    n = 1 + $urandom % 3;
    r0 = slowRises;
    osc_write(1'b1, n[7:0], 1'b0);
    check(stable, 1'b0);
    wait_high(0, 8 * 4 * 40 + 200);
    check_in(slowRises - r0, 8 * n - 1, 8 * n);
    wait_high(1, 20 * 40 + 100);
    // Counting runs from a slow rise to the sixteenth slow fall: fifteen and a half periods.
    e = 31 * SLOW_P / (2 * XTAL_P);
    check_in(freqCount, e - 2, e + 2);
    watch();
    check(selMain, 1'b1);
    check_in(mainT, 2 * WIN * 20 / XTAL_P - 2, 2 * WIN * 20 / XTAL_P + 2);
    $display("startup and measure test done");
    osc_write(1'b0, 8'h00, 1'b0);
    check(stable, 1'b0);
    @(negedge refClk);
    check({ready, freqCount, selMain}, 18'h00000);
    osc_write(1'b0, 8'h00, 1'b1);
    watch();
    check_in(mainT, 2 * WIN * 20 / XTAL_P - 2, 2 * WIN * 20 / XTAL_P + 2);
    check(stable, 1'b0);
    selectMain = 1'b0;
    repeat (2) @(negedge refClk);
    check(selMain, 1'b0);
    selectMain = 1'b1;
    $display("disable and bypass test done");
    for (i = 0; i < ratioQ.size(); i++) begin
      r = (i == 1) ? 2 + $urandom % 4 : ratioQ[i];
      f = factorQ[i];
      s = 2 + $urandom % 6;
      on = (r != 0 && f != 0);
      r0 = slowRises;
      pll_write(r, f, s);
      check(settled, 1'b0);
      if (on) begin
        wait_high(2, 10 * 40);
        check_in(slowRises - r0, s - 1, s + 1);
      end
      watch();
      e = on ? WIN * 2 * (f + 1) / (XTAL_P / 20 * r) : 0;
      e = (e > WIN) ? WIN : e;
      check_in(pllT, e * 9 / 10 - 2, e * 11 / 10 + 2);
      e = (r == 0) ? 0 : WIN / (XTAL_P / 20 * r);
      check_in(divR, e - 1, e + 1);
      if (!on) check(settled, 1'b0);
    end
    $display("pll test done");
    final_report();
  end
endmodule
